// ### hw/rx_front_pkg.sv
// Package with register map, field layouts and enumerations of the receive front end.
package rx_front_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PATTERN_OFS = 8'h04;
   localparam logic [7:0] RUNLEN_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;

   // Aligner mode codes in the control register.
   localparam logic [2:0] MODE_BITSLIP = 3'h0;
   localparam logic [2:0] MODE_16BIT = 3'h1;
   localparam logic [2:0] MODE_10BIT = 3'h2;
   localparam logic [2:0] MODE_XAUI = 3'h3;
   localparam logic [2:0] MODE_GIGABIT_ETHERNET = 3'h4;

   // Protocol codes in the control register.
   localparam logic [1:0] PROTO_CUSTOM = 2'h0;
   localparam logic [1:0] PROTO_SONET = 2'h1;
   localparam logic [1:0] PROTO_XAUI = 2'h2;
   localparam logic [1:0] PROTO_GIGABIT_ETHERNET = 2'h3;

   // Fixed comma and the low-seven-bit match mask, first bit in bit 0.
   localparam logic [9:0] COMMA_POS = 10'h17c;
   localparam logic [9:0] COMMA_MASK7 = 10'h07f;

   // Widths, limits and counts.
   localparam int HIST_W = 32;
   localparam int WORD_W = 20;
   localparam logic [3:0] NARROW_W = 4'h8;
   localparam logic [3:0] WIDE_W = 4'ha;
   localparam logic [7:0] PHASE_LIMIT_MUI = 8'h50;
   localparam logic [7:0] RUN_STEP_WIDE = 8'h05;
   localparam logic [7:0] RUN_STEP_NARROW = 8'h04;
   localparam logic [1:0] SYNC_GOOD_COMMAS = 2'h3;
   localparam logic [2:0] SYNC_BAD_COMMAS = 3'h4;

   // Reset value of the control register: bit-slip, custom, 125 PPM frequency threshold.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] PATTERN_RESET = 16'h017c;
   localparam logic [4:0] RUNLEN_RESET = 5'h1f;

   // Static configuration carried as one packed word.
   typedef struct packed {
      logic [1:0] ppm_sel;
      logic mask7;
      logic quad_pattern;
      logic double_width;
      logic slip_wide;
      logic [1:0] protocol;
      logic [2:0] mode;
   } cfg_t;

   // Aligned word output group.
   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic [1:0] pattern_hit;
      logic valid;
   } word_out_t;

   // Lock state of the clock recovery unit.
   typedef enum logic [1:0] {
      LOCK_REF = 2'b01,
      LOCK_DATA = 2'b10
   } lock_state_t;

   // Synchronization state of the fixed-protocol aligner.
   typedef enum logic [3:0] {
      SYNC_LOSS = 4'b0001,
      SYNC_DET = 4'b0010,
      SYNC_ACQ = 4'b0100,
      SYNC_HOLD = 4'b1000
   } sync_state_t;

endpackage : rx_front_pkg

// ### hw/rx_lock_deser_word_aligner.sv
// Receive front end: lock-mode control, deserializer and word aligner.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rx_lock_deser_word_aligner (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Clock recovery unit inputs.
   input wire logic ref_pll_locked_i,
   input wire logic [10:0] freq_err_ppm_i,
   input wire logic [7:0] phase_err_mui_i,
   input wire logic force_data_i,
   input wire logic force_ref_i,
   // Clock recovery unit outputs.
   output logic train_from_data_o,
   output logic locked_to_data_o,
   output logic ref_locked_n_o,
   // Serial input, one bit per clock when valid.
   input wire logic serial_bit_i,
   input wire logic serial_valid_i,
   // Fabric controls.
   input wire logic slip_req_i,
   input wire logic realign_req_i,
   input wire logic align_en_i,
   // Aligned word output.
   output logic [19:0] word_o,
   output logic word_valid_o,
   output logic [1:0] pattern_det_o,
   output logic aligned_o,
   output logic run_length_err_o
);

   // Configuration and state registers.
   rx_front_pkg::cfg_t cfg_q;
   logic [15:0] pattern_q;
   logic [4:0] runlen_code_q;
   rx_front_pkg::lock_state_t lock_q;
   rx_front_pkg::sync_state_t sync_q;
   rx_front_pkg::word_out_t out_q;
   logic [rx_front_pkg::HIST_W-1:0] hist_q;
   logic [3:0] cnt_q;
   logic slip_q;
   logic realign_q;
   logic slip_pend_q;
   logic searching_q;
   logic lane_q;
   logic [9:0] low_word_q;
   logic low_hit_q;
   logic aligned_q;
   logic [7:0] run_q;
   logic run_err_q;
   logic [1:0] good_q;
   logic [2:0] bad_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic train_q;
   logic ref_n_q;

   // Frequency threshold in PPM for each selector value.
   function automatic logic [10:0] ppm_limit(input logic [1:0] sel);
      case (sel)
         2'h0: ppm_limit = 11'h07d;
         2'h1: ppm_limit = 11'h0fa;
         2'h2: ppm_limit = 11'h1f4;
         default: ppm_limit = 11'h3e8;
      endcase
   endfunction : ppm_limit

   // Ten-bit match against a pattern and its inverse, optionally low seven.
   function automatic logic match10(input logic [9:0] w,
                                    input logic [9:0] p,
                                    input logic mask7);
      logic [9:0] m;
      m = mask7 ? rx_front_pkg::COMMA_MASK7 : 10'h3ff;
      match10 = (((w ^ p) & m) == 10'h000) || (((w ^ ~p) & m) == 10'h000);
   endfunction : match10

   // Decoded mode, width and legality.
   logic mode_legal;
   logic [3:0] wsel;
   logic [9:0] pat10;
   logic is_slip;
   logic is_16;
   logic is_10;
   logic is_sync;
   always_comb begin
      is_slip = cfg_q.mode == rx_front_pkg::MODE_BITSLIP;
      is_16 = cfg_q.mode == rx_front_pkg::MODE_16BIT;
      is_10 = cfg_q.mode == rx_front_pkg::MODE_10BIT;
      is_sync = (cfg_q.mode == rx_front_pkg::MODE_XAUI) ||
                (cfg_q.mode == rx_front_pkg::MODE_GIGABIT_ETHERNET);
      pat10 = is_sync ? rx_front_pkg::COMMA_POS : pattern_q[9:0];
      case (cfg_q.mode)
         rx_front_pkg::MODE_BITSLIP: begin
            mode_legal = (cfg_q.protocol == rx_front_pkg::PROTO_CUSTOM) ||
                         (cfg_q.protocol == rx_front_pkg::PROTO_SONET);
            wsel = cfg_q.slip_wide ? rx_front_pkg::WIDE_W
                                   : rx_front_pkg::NARROW_W;
         end
         rx_front_pkg::MODE_16BIT: begin
            mode_legal = (cfg_q.protocol == rx_front_pkg::PROTO_SONET) ||
                         ((cfg_q.protocol == rx_front_pkg::PROTO_CUSTOM) &&
                          !cfg_q.quad_pattern);
            wsel = rx_front_pkg::NARROW_W;
         end
         rx_front_pkg::MODE_10BIT: begin
            mode_legal = cfg_q.protocol == rx_front_pkg::PROTO_CUSTOM;
            wsel = rx_front_pkg::WIDE_W;
         end
         rx_front_pkg::MODE_XAUI: begin
            mode_legal = cfg_q.protocol == rx_front_pkg::PROTO_XAUI;
            wsel = rx_front_pkg::WIDE_W;
         end
         rx_front_pkg::MODE_GIGABIT_ETHERNET: begin
            mode_legal = cfg_q.protocol ==
                         rx_front_pkg::PROTO_GIGABIT_ETHERNET;
            wsel = rx_front_pkg::WIDE_W;
         end
         default: begin
            mode_legal = 1'b0;
            wsel = rx_front_pkg::WIDE_W;
         end
      endcase
   end

   // Bit history after this cycle's bit; the newest bit sits on top.
   logic [rx_front_pkg::HIST_W-1:0] hist_d;
   logic [9:0] word_now;
   logic word_end;
   assign hist_d = serial_valid_i ? {serial_bit_i, hist_q[31:1]} : hist_q;

   // The word ends when the bit counter reaches width minus one.
   always_comb begin
      word_end = serial_valid_i && !slip_pend_q && (cnt_q == wsel - 4'h1);
      if (wsel == rx_front_pkg::WIDE_W) begin
         word_now = hist_d[31:22];
      end else begin
         word_now = {2'b00, hist_d[31:24]};
      end
   end

   // Boundary search hits for the automatic modes.
   logic hit16;
   logic hit10;
   logic auto_hit;
   always_comb begin
      if (cfg_q.quad_pattern) begin
         hit16 = hist_d == {pattern_q[15:8], pattern_q[15:8],
                            pattern_q[7:0], pattern_q[7:0]};
      end else begin
         hit16 = hist_d[31:16] == pattern_q;
      end
      hit10 = match10(hist_d[31:22], pat10, cfg_q.mask7 && !is_sync);
      auto_hit = serial_valid_i && mode_legal && searching_q &&
                 ((is_16 && hit16) ||
                  (is_10 && align_en_i && hit10) ||
                  (is_sync && hit10 && (sync_q == rx_front_pkg::SYNC_LOSS)));
   end

   // Request edges from the fabric.
   logic slip_edge;
   logic realign_edge;
   assign slip_edge = slip_req_i && !slip_q;
   assign realign_edge = realign_req_i && !realign_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         slip_q <= 1'b0;
         realign_q <= 1'b0;
      end else begin
         slip_q <= slip_req_i;
         realign_q <= realign_req_i;
      end
   end

   // A slip holds the bit counter back one bit, moving the boundary by one.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         slip_pend_q <= 1'b0;
      end else if (slip_edge && is_slip && mode_legal) begin
         slip_pend_q <= 1'b1;
      end else if (serial_valid_i) begin
         slip_pend_q <= 1'b0;
      end
   end

   // Bit history and bit counter; a boundary hit restarts the count.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hist_q <= '0;
         cnt_q <= 4'h0;
      end else begin
         hist_q <= hist_d;
         if (auto_hit) begin
            cnt_q <= 4'h0;
         end else if (serial_valid_i && !slip_pend_q) begin
            cnt_q <= word_end ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end

   // Searching flag: cleared on 16-bit alignment, set again by realign or by any other mode.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         searching_q <= 1'b1;
      end else if (realign_edge && is_16) begin
         searching_q <= 1'b1;
      end else if (auto_hit && is_16) begin
         searching_q <= 1'b0;
      end else if (!is_16) begin
         searching_q <= 1'b1;
      end
   end

   // Pattern flag for the finished word, in the width in use.
   logic word_hit;
   always_comb begin
      if (wsel == rx_front_pkg::WIDE_W) begin
         word_hit = match10(word_now, pat10, cfg_q.mask7);
      end else begin
         word_hit = word_now[7:0] == pattern_q[7:0];
      end
   end

   // Word output, paired into twenty bits (sixteen for eight-bit words) in double-width mode.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         out_q <= '0;
         lane_q <= 1'b0;
         low_word_q <= 10'h000;
         low_hit_q <= 1'b0;
      end else begin
         // Flags pulse with the word so no stale hit outlives it.
         out_q.valid <= 1'b0;
         out_q.pattern_hit <= 2'b00;
         if (word_end) begin
            if (!cfg_q.double_width) begin
               out_q.data <= {10'h000, word_now};
               out_q.pattern_hit <= {1'b0, word_hit};
               out_q.valid <= 1'b1;
            end else if (!lane_q) begin
               low_word_q <= word_now;
               low_hit_q <= word_hit;
               lane_q <= 1'b1;
            end else begin
               out_q.data <= (wsel == rx_front_pkg::WIDE_W)
                             ? {word_now, low_word_q}
                             : {4'h0, word_now[7:0], low_word_q[7:0]};
               out_q.pattern_hit <= {word_hit, low_hit_q};
               out_q.valid <= 1'b1;
               lane_q <= 1'b0;
            end
         end
      end
   end

   // Fixed-protocol sync machine: three aligned commas acquire, four
   // misaligned ones lose it; the code-group checks of the standards are
   // left to the decoder stage.
   logic comma_here;
   assign comma_here = serial_valid_i && is_sync && mode_legal && hit10;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_q <= rx_front_pkg::SYNC_LOSS;
         good_q <= 2'h0;
         bad_q <= 3'h0;
      end else if (!is_sync || !mode_legal) begin
         sync_q <= rx_front_pkg::SYNC_LOSS;
         good_q <= 2'h0;
         bad_q <= 3'h0;
      end else begin
         case (sync_q)
            rx_front_pkg::SYNC_LOSS: begin
               if (comma_here) begin
                  sync_q <= rx_front_pkg::SYNC_DET;
                  good_q <= 2'h1;
               end
            end
            rx_front_pkg::SYNC_DET: begin
               if (comma_here && !word_end) begin
                  sync_q <= rx_front_pkg::SYNC_LOSS;
               end else if (comma_here) begin
                  good_q <= good_q + 2'h1;
                  if (good_q + 2'h1 == rx_front_pkg::SYNC_GOOD_COMMAS) begin
                     sync_q <= rx_front_pkg::SYNC_ACQ;
                  end
               end
            end
            rx_front_pkg::SYNC_ACQ: begin
               if (comma_here && !word_end) begin
                  bad_q <= 3'h1;
                  sync_q <= rx_front_pkg::SYNC_HOLD;
               end
            end
            rx_front_pkg::SYNC_HOLD: begin
               if (comma_here && word_end) begin
                  bad_q <= 3'h0;
                  sync_q <= rx_front_pkg::SYNC_ACQ;
               end else if (comma_here) begin
                  bad_q <= bad_q + 3'h1;
                  if (bad_q + 3'h1 == rx_front_pkg::SYNC_BAD_COMMAS) begin
                     sync_q <= rx_front_pkg::SYNC_LOSS;
                     good_q <= 2'h0;
                  end
               end
            end
            default: sync_q <= rx_front_pkg::SYNC_LOSS;
         endcase
      end
   end

   // Run-length detector against the static threshold.
   logic [7:0] run_limit;
   assign run_limit = 8'((runlen_code_q + 5'h01) *
                         ((wsel == rx_front_pkg::WIDE_W) ?
                          rx_front_pkg::RUN_STEP_WIDE :
                          rx_front_pkg::RUN_STEP_NARROW));
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         run_q <= 8'h00;
         run_err_q <= 1'b0;
      end else if (serial_valid_i) begin
         if (serial_bit_i != hist_q[31]) begin
            run_q <= 8'h01;
         end else if (run_q != 8'hff) begin
            run_q <= run_q + 8'h01;
         end
         run_err_q <= (serial_bit_i == hist_q[31]) &&
                      (run_q >= run_limit);
      end
   end

   // Lock-mode control: force-data first, then force-reference, else auto.
   logic freq_ok;
   logic phase_ok;
   assign freq_ok = freq_err_ppm_i <= ppm_limit(cfg_q.ppm_sel);
   assign phase_ok = phase_err_mui_i <= rx_front_pkg::PHASE_LIMIT_MUI;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lock_q <= rx_front_pkg::LOCK_REF;
      end else if (force_data_i) begin
         lock_q <= rx_front_pkg::LOCK_DATA;
      end else if (force_ref_i) begin
         lock_q <= rx_front_pkg::LOCK_REF;
      end else begin
         // Both overrides low, as when left unconnected, is automatic.
         case (lock_q)
            rx_front_pkg::LOCK_REF: begin
               if (freq_ok && phase_ok && ref_pll_locked_i) begin
                  lock_q <= rx_front_pkg::LOCK_DATA;
               end
            end
            rx_front_pkg::LOCK_DATA: begin
               if (!freq_ok) begin
                  lock_q <= rx_front_pkg::LOCK_REF;
               end
            end
            default: lock_q <= rx_front_pkg::LOCK_REF;
         endcase
      end
   end

   // Lock status pins, registered.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         train_q <= 1'b0;
         ref_n_q <= 1'b1;
      end else begin
         train_q <= lock_q == rx_front_pkg::LOCK_DATA;
         ref_n_q <= !ref_pll_locked_i;
      end
   end

   // APB slave: one wait state, then the answer; unmapped gives an error.
   logic acc;
   logic [31:0] status_w;
   assign acc = psel_i && penable_i && !pready_q;
   assign status_w = {22'h000000, run_err_q, !searching_q, sync_q,
                      !mode_legal, 2'b00, lock_q == rx_front_pkg::LOCK_DATA};
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         if (acc) begin
            case (paddr_i)
               rx_front_pkg::CTRL_OFS: prdata_q <= {21'h000000, cfg_q};
               rx_front_pkg::PATTERN_OFS: prdata_q <= {16'h0000, pattern_q};
               rx_front_pkg::RUNLEN_OFS: prdata_q <= {27'h0000000, runlen_code_q};
               rx_front_pkg::STATUS_OFS: prdata_q <= status_w;
               default: pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   // Register writes take effect in the cycle the access completes.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= rx_front_pkg::cfg_t'(rx_front_pkg::CTRL_RESET[10:0]);
         pattern_q <= rx_front_pkg::PATTERN_RESET;
         runlen_code_q <= rx_front_pkg::RUNLEN_RESET;
      end else if (psel_i && penable_i && pready_q && pwrite_i) begin
         case (paddr_i)
            rx_front_pkg::CTRL_OFS: cfg_q <= rx_front_pkg::cfg_t'(pwdata_i[10:0]);
            rx_front_pkg::PATTERN_OFS: pattern_q <= pwdata_i[15:0];
            rx_front_pkg::RUNLEN_OFS: runlen_code_q <= pwdata_i[4:0];
            default: ;
         endcase
      end
   end

   // Alignment status; registered, so it trails the search state by a cycle.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         aligned_q <= 1'b0;
      end else begin
         aligned_q <= !searching_q || (sync_q == rx_front_pkg::SYNC_ACQ);
      end
   end

   // Outputs straight from flip-flops.
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign train_from_data_o = train_q;
   assign locked_to_data_o = train_q;
   assign ref_locked_n_o = ref_n_q;
   assign word_o = out_q.data;
   assign word_valid_o = out_q.valid;
   assign pattern_det_o = out_q.pattern_hit;
   assign aligned_o = aligned_q;
   assign run_length_err_o = run_err_q;

endmodule : rx_lock_deser_word_aligner
`default_nettype wire

// ### dv/rx_front_checker.sv
// Checker for lock control, word pulses and bus timing at the top ports.
`timescale 1ns/1ps
`default_nettype none
module rx_front_checker (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Watched ports.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic ref_pll_locked_i,
   input wire logic force_data_i,
   input wire logic force_ref_i,
   input wire logic [7:0] phase_err_mui_i,
   input wire logic serial_valid_i,
   input wire logic train_from_data_o,
   input wire logic locked_to_data_o,
   input wire logic ref_locked_n_o,
   input wire logic word_valid_o,
   input wire logic [1:0] pattern_det_o
);
   // One clock domain, so clocking and disable are shared.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   a_force_data_wins:
      assert property ((force_data_i && !sys_rst_i)[*3] |-> train_from_data_o)
      else $error("Forced data lock not taken.");
   a_force_ref_wins:
      assert property ((force_ref_i && !force_data_i && !sys_rst_i)[*3]
         |-> !train_from_data_o) else $error("Forced reference lock lost.");
   // State takes its inputs two edges before the output rises.
   a_auto_phase_gate:
      assert property ($rose(train_from_data_o) && !$past(force_data_i, 2)
         |-> $past(phase_err_mui_i, 2) <= 8'h50 && $past(ref_pll_locked_i, 2))
      else $error("Data lock taken with phase out of range.");
   a_locked_mirror:
      assert property (locked_to_data_o == train_from_data_o)
      else $error("Data lock flag differs from lock state.");
   a_ref_lock_copy:
      assert property (!$past(sys_rst_i) |-> ref_locked_n_o
         == !$past(ref_pll_locked_i)) else $error("Reference lock flag wrong.");
   a_word_one_pulse:
      assert property (word_valid_o |=> !word_valid_o)
      else $error("Word valid longer than one cycle.");
   a_word_after_bit:
      assert property (word_valid_o |-> $past(serial_valid_i))
      else $error("Word emitted without a bit taken.");
   a_flag_with_word:
      assert property (|pattern_det_o |-> word_valid_o)
      else $error("Pattern flag outside a word.");
   a_apb_one_wait:
      assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("Bus answer not one wait state.");
   c_data_lock: cover property ($rose(train_from_data_o));
   c_pattern: cover property (|pattern_det_o);
   c_bus: cover property (pready_o);
endmodule : rx_front_checker
bind rx_lock_deser_word_aligner rx_front_checker chk_u (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .ref_pll_locked_i(ref_pll_locked_i),
   .force_data_i(force_data_i), .force_ref_i(force_ref_i),
   .phase_err_mui_i(phase_err_mui_i), .serial_valid_i(serial_valid_i),
   .train_from_data_o(train_from_data_o),
   .locked_to_data_o(locked_to_data_o), .ref_locked_n_o(ref_locked_n_o),
   .word_valid_o(word_valid_o), .pattern_det_o(pattern_det_o));
`default_nettype wire

// ### dv/serial_tx_model.sv
// Remote serial transmitter model that feeds the line first bit first.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   // Clock.
   input wire logic clk_i,
   // Serial line.
   output logic bit_o,
   output logic valid_o
);
   initial begin
      bit_o = 1'b0;
      valid_o = 1'b0;
   end
   // Idle line shows the inverse bit, so stale data never looks valid.
   task automatic send(input logic [9:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         bit_o <= w[i];
         valid_o <= 1'b1;
      end
      @(posedge clk_i);
      bit_o <= ~bit_o;
      valid_o <= 1'b0;
   endtask : send
endmodule : serial_tx_model
`default_nettype wire

// ### dv/test_rx_lock_deser_word_aligner.sv
// Self-checking bench for lock control, deserializer and word aligner.
`timescale 1ns/1ps
`default_nettype none
module test_rx_lock_deser_word_aligner;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic ref_pll_locked_i = 1'b0;
   logic [10:0] freq_err_ppm_i = 11'h7ff;
   logic [7:0] phase_err_mui_i = 8'hff;
   logic force_data_i = 1'b0;
   logic force_ref_i = 1'b0;
   logic slip_req_i = 1'b0;
   logic align_en_i = 1'b1;
   logic realign_req_i = 1'b0;
   logic serial_bit_i, serial_valid_i, pready_o, pslverr_o, err;
   logic train_from_data_o, locked_to_data_o, ref_locked_n_o;
   logic word_valid_o, aligned_o, run_length_err_o;
   logic [31:0] prdata_o, rd;
   logic [19:0] word_o;
   logic [1:0] pattern_det_o;
   logic [10:0] q[$];
   logic [7:0] ofs[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
   logic [31:0] rst_val[4] = '{32'h0, 32'h17c, 32'h1f, 32'h0};
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   // The clock period is 4 ns.
   always #2 clk_i = ~clk_i;
   rx_lock_deser_word_aligner dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ref_pll_locked_i(ref_pll_locked_i), .freq_err_ppm_i(freq_err_ppm_i),
      .phase_err_mui_i(phase_err_mui_i), .force_data_i(force_data_i),
      .force_ref_i(force_ref_i), .train_from_data_o(train_from_data_o),
      .locked_to_data_o(locked_to_data_o), .ref_locked_n_o(ref_locked_n_o),
      .serial_bit_i(serial_bit_i), .serial_valid_i(serial_valid_i),
      .slip_req_i(slip_req_i), .realign_req_i(realign_req_i),
      .align_en_i(align_en_i),
      .word_o(word_o), .word_valid_o(word_valid_o),
      .pattern_det_o(pattern_det_o), .aligned_o(aligned_o),
      .run_length_err_o(run_length_err_o));
   serial_tx_model tx_u (.clk_i(clk_i), .bit_o(serial_bit_i),
      .valid_o(serial_valid_i));
   // Words are logged with their lane 0 pattern flag.
   always @(posedge clk_i) begin
      if (word_valid_o === 1'b1) begin
         q.push_back({pattern_det_o[0], word_o[9:0]});
      end
   end
   // A hang ends the run as a failure.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(input string n, input logic [31:0] s, x);
      checked++;
      if (s !== x) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask : wait_n
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic lock(input logic fd, fr, input logic [7:0] ph,
      input logic [10:0] fq, input logic x);
      @(posedge clk_i);
      force_data_i <= fd;
      force_ref_i <= fr;
      phase_err_mui_i <= ph;
      freq_err_ppm_i <= fq;
      wait_n(4);
      check("train_from_data_o", {31'h0, train_from_data_o}, {31'h0, x});
   endtask : lock
   task automatic tally_and_finish();
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ofs[i], 32'h0, rd, err);
         check("prdata_o", rd, rst_val[i]);
         check("pslverr_o", {31'h0, err}, {31'h0, i == 3});
      end
      check("ref_locked_n_o", {31'h0, ref_locked_n_o}, 32'h1);
      lock(1'b1, 1'b1, 8'hff, 11'h7ff, 1'b1);
      @(posedge clk_i);
      ref_pll_locked_i <= 1'b1;
      lock(1'b0, 1'b1, 8'h00, 11'h000, 1'b0);
      check("ref_locked_n_o", {31'h0, ref_locked_n_o}, 32'h0);
      lock(1'b0, 1'b0, 8'h51, 11'h07d, 1'b0);
      lock(1'b0, 1'b0, 8'h50, 11'h07d, 1'b1);
      lock(1'b0, 1'b0, 8'h50, 11'h07e, 1'b0);
      lock(1'b0, 1'b0, 8'h00, 11'h000, 1'b1);
      apb(1'b0, 8'h0c, 32'h0, rd, err);
      check("status lock", {31'h0, rd[0]}, 32'h1);
      apb(1'b1, 8'h00, 32'h0000_0022, rd, err);
      tx_u.send(10'h005, 3);
      tx_u.send(10'h17c, 10);
      tx_u.send(10'h2a5, 10);
      tx_u.send(10'h283, 10);
      tx_u.send(10'h0cc, 10);
      wait_n(3);
      check("word a", {21'h0, q[q.size()-3]}, 32'h2a5);
      check("word b", {21'h0, q[q.size()-2]}, 32'h683);
      check("word c", {21'h0, q[q.size()-1]}, 32'h0cc);
      @(posedge clk_i);
      align_en_i <= 1'b0;
      tx_u.send(10'h005, 3);
      tx_u.send(10'h17c, 10);
      tx_u.send(10'h2a5, 10);
      wait_n(3);
      check("held word", {21'h0, q[$]}, 32'h12a);
      apb(1'b1, 8'h00, 32'h0000_0020, rd, err);
      q.delete();
      fork
         repeat (8) tx_u.send(10'h001, 10);
         begin
            repeat (50) @(posedge clk_i);
            slip_req_i <= 1'b1;
            @(posedge clk_i);
            slip_req_i <= 1'b0;
         end
      join
      wait_n(3);
      check("pre slip", {22'h0, q[2][9:0]}, 32'h008);
      check("slipped", {22'h0, q[$][9:0]}, 32'h004);
      apb(1'b1, 8'h08, 32'h0, rd, err);
      apb(1'b1, 8'h00, 32'h0000_0001, rd, err);
      tx_u.send(10'h07c, 8);
      tx_u.send(10'h001, 8);
      wait_n(2);
      check("aligned_o", {31'h0, aligned_o}, 32'h1);
      @(posedge clk_i);
      realign_req_i <= 1'b1;
      wait_n(2);
      check("aligned_o", {31'h0, aligned_o}, 32'h0);
      tx_u.send(10'h3ff, 10);
      wait_n(1);
      check("run_length_err_o", {31'h0, run_length_err_o}, 32'h1);
      apb(1'b1, 8'h00, 32'h0000_0013, rd, err);
      repeat (3) tx_u.send(10'h17c, 10);
      wait_n(2);
      check("aligned_o", {31'h0, aligned_o}, 32'h1);
      tally_and_finish();
   end
endmodule : test_rx_lock_deser_word_aligner
`default_nettype wire
